//--- design/oled_cmd_host.sv
`timescale 1ns/100ps
// Host end: turns one request into the byte sequence of a command.
module oled_cmd_host (
  // Clock and reset.
  input wire logic clock,
  input wire logic nrst,
  // Request from user logic.
  input wire logic req_valid,
  input wire logic [2:0] req_kind,
  input wire logic [7:0] req_arg0,
  input wire logic [7:0] req_arg1,
  input wire logic [7:0] req_arg2,
  input wire logic [7:0] req_arg3,
  output logic req_ready,
  // Byte port to the device.
  oled_cmd_if.host bus
);

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // Kinds: 0 scroll setup (arg0 bit0 dir, arg1..3), 1 mode, 2 activate,
  // 3 pump, 4 start line, 5 contrast (arg0 value), others one raw opcode.
  logic [7:0] seq_ff [0:4], nxt_seq [0:4]; // Bytes still to send.
  logic [2:0] cnt_ff, nxt_cnt; // Count of bytes left.
  logic stb_ff, nxt_stb;
  logic [7:0] byte_ff, nxt_byte;

  assign req_ready = (cnt_ff == 3'h0);

  // Load a sequence on request, then send one byte per cycle.
  always_comb begin
    nxt_seq = seq_ff;
    nxt_cnt = cnt_ff;
    nxt_stb = 1'b0;
    nxt_byte = byte_ff;
    if (cnt_ff != 3'h0) begin
      nxt_stb = 1'b1;
      nxt_byte = seq_ff[0];
      nxt_seq[0:3] = seq_ff[1:4];
      nxt_cnt = cnt_ff - 3'h1;
    end else if (req_valid) begin
      nxt_cnt = 3'h1;
      case (req_kind)
        3'h0: begin
          // The deactivate goes first so memory is safe during setup.
          nxt_seq[0] = {oled_cmd_pkg::op_act_base[7:1], 1'b0};
          nxt_seq[1] = {oled_cmd_pkg::op_hscroll_base[7:1], req_arg0[0]};
          nxt_seq[2] = req_arg1;
          nxt_seq[3] = req_arg2;
          nxt_seq[4] = req_arg3;
          nxt_cnt = 3'h5;
        end
        3'h1: nxt_seq[0] = oled_cmd_pkg::op_mode_base | {6'h00, req_arg0[1:0]};
        3'h2: nxt_seq[0] = {oled_cmd_pkg::op_act_base[7:1], req_arg0[0]};
        3'h3: nxt_seq[0] = oled_cmd_pkg::op_pump_base | {6'h00, req_arg0[1:0]};
        3'h4: nxt_seq[0] = oled_cmd_pkg::op_line_base | {2'h0, req_arg0[5:0]};
        3'h5: begin
          nxt_seq[0] = oled_cmd_pkg::op_contrast;
          nxt_seq[1] = req_arg0;
          nxt_cnt = 3'h2;
        end
        default: nxt_seq[0] = req_arg0;
      endcase
    end
  end

  // Registers of the sequencer.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 5; i++) begin
        seq_ff[i] <= 8'h00;
      end
      cnt_ff <= 3'h0;
      stb_ff <= 1'b0;
      byte_ff <= 8'h00;
    end else begin
      seq_ff <= nxt_seq;
      cnt_ff <= nxt_cnt;
      stb_ff <= nxt_stb;
      byte_ff <= nxt_byte;
    end
  end

  assign bus.wr_stb = stb_ff;
  assign bus.wr_byte = byte_ff;
  // Every byte of these commands is sent as command.
  assign bus.cmd_data_select = 1'b0;

endmodule

//--- design/oled_scroll_contrast_cmd_decoder.sv
`timescale 1ns/100ps
// Summary of operation
// - Scroll setup is opcode plus three parameter bytes.
// - First parameter bits 2:0 give start page.
// - Second parameter bits 2:0 select frame interval.
// - Third parameter bits 2:0 give end page.
// - Host deactivates scroll before scroll setup.
// - Mode opcode: 00 continuous, 01 single, 1x column.
// - Column mode shifts one column per activate.
// - Activate opcode bit 0 starts or stops scroll.
// - Host activates only after all setup.
// - Host leaves setup alone while scrolling.
// - Deactivate returns image to unscrolled position.
// - Pump opcode bits 1:0 select pump voltage.
// - Start line opcode sets top row line.
// - Following rows ascend from the start line.
// - Contrast is opcode then eight-bit value.
// - Byte after contrast opcode is data only.
// - Contrast resets to 80h, advised idle value.
// - Decode only when select pin is low.
// - Start line resets to zero.
module oled_scroll_contrast_cmd_decoder #(
  parameter int unsigned cols = 128
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic nrst,
  // Command byte port from the host.
  oled_cmd_if.device bus,
  // Frame timing from the display timing logic.
  input wire logic frame_tick,
  // Row being scanned, used to map memory lines.
  input wire logic [5:0] row_index,
  // Decoded settings to the display logic.
  output logic scroll_left,
  output logic [2:0] start_page,
  output logic [2:0] end_page,
  output logic [2:0] interval_code,
  output oled_cmd_pkg::scroll_mode_t scroll_mode,
  output logic scroll_active,
  output logic [6:0] scroll_offset,
  output logic scroll_step,
  output logic [1:0] pump_level,
  output logic [5:0] start_line,
  output logic [5:0] mem_line,
  output logic [7:0] contrast,
  output logic busy_param
);

  // Offsets are seven bits wide, so wider screens cannot be counted.
  if (cols < 2 || cols > 128) begin : g_bad_cols
    $error("cols must lie in 2..128");
  end

  // ---------------------------------------------------------------
  // Decoder state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {st_idle, st_hscroll, st_contrast} dec_state_t;

  dec_state_t state_ff, nxt_state; // What the next byte means.
  logic [2:0] left_ff, nxt_left; // Parameter bytes still expected.
  logic dir_ff, nxt_dir; // Scroll direction.
  logic [2:0] spage_ff, nxt_spage; // Start page.
  logic [2:0] ivl_ff, nxt_ivl; // Interval code.
  logic [2:0] epage_ff, nxt_epage; // End page.
  oled_cmd_pkg::scroll_mode_t mode_ff, nxt_mode; // Scroll mode.
  logic act_ff, nxt_act; // Scroll motion enabled.
  logic col_req_ff, nxt_col_req; // One-column shift pending.
  logic [1:0] pump_ff, nxt_pump; // Pump voltage code.
  logic [5:0] line_ff, nxt_line; // Display start line.
  logic [7:0] con_ff, nxt_con; // Contrast value.
  logic cmd_wr; // A byte written as command.

  // ---------------------------------------------------------------
  // Byte decode
  // ---------------------------------------------------------------
  // Writes with the select pin high are display data and ignored here.
  assign cmd_wr = bus.wr_stb && !bus.cmd_data_select;

  // Opcodes are recognised only in idle; parameter bytes never decode.
  always_comb begin
    nxt_state = state_ff;
    nxt_left = left_ff;
    nxt_dir = dir_ff;
    nxt_spage = spage_ff;
    nxt_ivl = ivl_ff;
    nxt_epage = epage_ff;
    nxt_mode = mode_ff;
    nxt_act = act_ff;
    nxt_col_req = 1'b0;
    nxt_pump = pump_ff;
    nxt_line = line_ff;
    nxt_con = con_ff;
    if (cmd_wr) begin
      case (state_ff)
        st_hscroll: begin
          // Bits 7:3 of every parameter byte are don't care.
          case (left_ff)
            3'h3: nxt_spage = bus.wr_byte[2:0];
            3'h2: nxt_ivl = bus.wr_byte[2:0];
            default: nxt_epage = bus.wr_byte[2:0];
          endcase
          nxt_left = left_ff - 3'h1;
          if (left_ff == 3'h1) begin
            nxt_state = st_idle;
          end
        end
        st_contrast: begin
          // Whatever the value, this byte is data and ends the mode.
          nxt_con = bus.wr_byte;
          nxt_state = st_idle;
        end
        default: begin
          if (oled_cmd_pkg::op_match(bus.wr_byte, oled_cmd_pkg::op_hscroll_base,
                                     oled_cmd_pkg::op_hscroll_mask)) begin
            nxt_dir = bus.wr_byte[0];
            nxt_left = oled_cmd_pkg::hscroll_params;
            nxt_state = st_hscroll;
          end else if (oled_cmd_pkg::op_match(bus.wr_byte, oled_cmd_pkg::op_mode_base,
                                              oled_cmd_pkg::op_mode_mask)) begin
            if (bus.wr_byte[1]) begin
              nxt_mode = oled_cmd_pkg::mode_one_column;
            end else if (bus.wr_byte[0]) begin
              nxt_mode = oled_cmd_pkg::mode_single;
            end else begin
              nxt_mode = oled_cmd_pkg::mode_continuous;
            end
          end else if (oled_cmd_pkg::op_match(bus.wr_byte, oled_cmd_pkg::op_act_base,
                                              oled_cmd_pkg::op_act_mask)) begin
            nxt_act = bus.wr_byte[0];
            // In column mode each activate asks for exactly one shift.
            nxt_col_req = bus.wr_byte[0] && (mode_ff == oled_cmd_pkg::mode_one_column);
          end else if (oled_cmd_pkg::op_match(bus.wr_byte, oled_cmd_pkg::op_pump_base,
                                              oled_cmd_pkg::op_pump_mask)) begin
            nxt_pump = bus.wr_byte[1:0];
          end else if (oled_cmd_pkg::op_match(bus.wr_byte, oled_cmd_pkg::op_line_base,
                                              oled_cmd_pkg::op_line_mask)) begin
            nxt_line = bus.wr_byte[5:0];
          end else if (bus.wr_byte == oled_cmd_pkg::op_contrast) begin
            nxt_state = st_contrast;
          end
        end
      endcase
    end
  end

  // Registers of the decoder; reset gives the power-on settings.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_ff <= st_idle;
      left_ff <= 3'h0;
      dir_ff <= 1'b0;
      spage_ff <= oled_cmd_pkg::rst_start_page;
      ivl_ff <= oled_cmd_pkg::rst_interval;
      epage_ff <= oled_cmd_pkg::rst_end_page;
      mode_ff <= oled_cmd_pkg::mode_continuous;
      act_ff <= 1'b0;
      col_req_ff <= 1'b0;
      pump_ff <= oled_cmd_pkg::rst_pump;
      line_ff <= oled_cmd_pkg::rst_start_line;
      con_ff <= oled_cmd_pkg::rst_contrast;
    end else begin
      state_ff <= nxt_state;
      left_ff <= nxt_left;
      dir_ff <= nxt_dir;
      spage_ff <= nxt_spage;
      ivl_ff <= nxt_ivl;
      epage_ff <= nxt_epage;
      mode_ff <= nxt_mode;
      act_ff <= nxt_act;
      col_req_ff <= nxt_col_req;
      pump_ff <= nxt_pump;
      line_ff <= nxt_line;
      con_ff <= nxt_con;
    end
  end

  // ---------------------------------------------------------------
  // Scroll engine
  // ---------------------------------------------------------------
  logic [7:0] frame_cnt_ff, nxt_frame_cnt; // Frames since last step.
  logic [6:0] offset_ff, nxt_offset; // Current column offset.
  logic step_ff, nxt_step; // One-cycle step strobe.
  logic done_ff, nxt_done; // Single screen pass finished.
  logic [6:0] last_col; // Highest offset value.

  assign last_col = 7'(cols - 1);

  // Continuous mode wraps forever, single screen stops after a full pass,
  // column mode moves once per activate and ignores the frame count.
  always_comb begin
    nxt_frame_cnt = frame_cnt_ff;
    nxt_offset = offset_ff;
    nxt_step = 1'b0;
    nxt_done = done_ff;
    if (!act_ff) begin
      // Stopping scroll snaps the picture back home.
      nxt_offset = 7'h00;
      nxt_frame_cnt = 8'h00;
      nxt_done = 1'b0;
    end else if (mode_ff == oled_cmd_pkg::mode_one_column) begin
      if (col_req_ff) begin
        nxt_step = 1'b1;
        nxt_offset = (offset_ff == last_col) ? 7'h00 : offset_ff + 7'h01;
      end
    end else if (frame_tick && !done_ff) begin
      if (frame_cnt_ff + 8'h01 >= oled_cmd_pkg::interval_frames(ivl_ff)) begin
        nxt_frame_cnt = 8'h00;
        nxt_step = 1'b1;
        nxt_offset = (offset_ff == last_col) ? 7'h00 : offset_ff + 7'h01;
        nxt_done = (mode_ff == oled_cmd_pkg::mode_single) && (offset_ff == last_col);
      end else begin
        nxt_frame_cnt = frame_cnt_ff + 8'h01;
      end
    end
  end

  // Registers of the scroll engine.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      frame_cnt_ff <= 8'h00;
      offset_ff <= 7'h00;
      step_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      frame_cnt_ff <= nxt_frame_cnt;
      offset_ff <= nxt_offset;
      step_ff <= nxt_step;
      done_ff <= nxt_done;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign scroll_left = dir_ff;
  assign start_page = spage_ff;
  assign end_page = epage_ff;
  assign interval_code = ivl_ff;
  assign scroll_mode = mode_ff;
  assign scroll_active = act_ff;
  assign scroll_offset = offset_ff;
  assign scroll_step = step_ff;
  assign pump_level = pump_ff;
  assign start_line = line_ff;
  // Six-bit wrap gives ascending lines from the start line.
  assign mem_line = line_ff + row_index;
  assign contrast = con_ff;
  assign busy_param = (state_ff != st_idle);

endmodule

//--- include/oled_cmd_if.sv
`timescale 1ns/100ps
// Write strobe with a byte and the command/data select level.
interface oled_cmd_if;
  logic wr_stb;
  logic [7:0] wr_byte;
  logic cmd_data_select;

  modport host (output wr_stb, output wr_byte, output cmd_data_select);
  modport device (input wr_stb, input wr_byte, input cmd_data_select);
endinterface

//--- include/oled_cmd_pkg.sv
package oled_cmd_pkg;

  // ---------------------------------------------------------------
  // Opcode patterns and masks
  // ---------------------------------------------------------------
  // Horizontal scroll setup, bit 0 is the direction.
  localparam logic [7:0] op_hscroll_base = 8'h26;
  localparam logic [7:0] op_hscroll_mask = 8'hfe;
  // Scroll mode, bits 1:0 carry the mode.
  localparam logic [7:0] op_mode_base = 8'h28;
  localparam logic [7:0] op_mode_mask = 8'hfc;
  // Scroll deactivate and activate, bit 0 is the enable.
  localparam logic [7:0] op_act_base = 8'h2e;
  localparam logic [7:0] op_act_mask = 8'hfe;
  // Pump voltage, bits 1:0 carry the level.
  localparam logic [7:0] op_pump_base = 8'h30;
  localparam logic [7:0] op_pump_mask = 8'hfc;
  // Display start line, bits 5:0 carry the line.
  localparam logic [7:0] op_line_base = 8'h40;
  localparam logic [7:0] op_line_mask = 8'hc0;
  // Contrast mode opcode, followed by one data byte.
  localparam logic [7:0] op_contrast = 8'h81;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] rst_start_page = 3'h0;
  localparam logic [2:0] rst_interval = 3'h0;
  localparam logic [2:0] rst_end_page = 3'h7;
  localparam logic [1:0] rst_pump = 2'h2;
  localparam logic [5:0] rst_start_line = 6'h00;
  localparam logic [7:0] rst_contrast = 8'h80;
  localparam logic [2:0] hscroll_params = 3'h3;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    mode_continuous,
    mode_single,
    mode_one_column
  } scroll_mode_t;

  // Frames per scroll step for the 3-bit interval code.
  function automatic logic [7:0] interval_frames(input logic [2:0] code);
    case (code)
      3'h0: interval_frames = 8'h06;
      3'h1: interval_frames = 8'h20;
      3'h2: interval_frames = 8'h40;
      3'h3: interval_frames = 8'h80;
      3'h4: interval_frames = 8'h03;
      3'h5: interval_frames = 8'h04;
      3'h6: interval_frames = 8'h05;
      default: interval_frames = 8'h02;
    endcase
  endfunction

  // True when a byte matches an opcode family.
  function automatic logic op_match(input logic [7:0] b, input logic [7:0] base,
                                    input logic [7:0] mask);
    op_match = ((b & mask) == base);
  endfunction

endpackage

//--- sim/oled_cmd_asserts.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Checker on the command wire and the decoded settings
// ---------------------------------------------------------------
module oled_cmd_asserts (
  // Clock and reset.
  input logic clock,
  input logic nrst,
  // Command wire between the two ends.
  input logic wr_stb,
  input logic [7:0] wr_byte,
  input logic cmd_data_select,
  // Decoded settings of the decoder.
  input logic busy_param,
  input logic scroll_left,
  input logic [2:0] start_page,
  input logic [2:0] end_page,
  input logic [2:0] interval_code,
  input oled_cmd_pkg::scroll_mode_t scroll_mode,
  input logic scroll_active,
  input logic [6:0] scroll_offset,
  input logic [1:0] pump_level,
  input logic [5:0] start_line,
  input logic [5:0] row_index,
  input logic [5:0] mem_line,
  input logic [7:0] contrast
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // A byte is an opcode only when no parameter byte is still pending.
  logic op;
  assign op = wr_stb && !cmd_data_select && !busy_param;

  property p_sel_low;
    wr_stb |-> !cmd_data_select;
  endproperty
  a_sel_low: assert property (p_sel_low)
    else $error("byte sent with select high");
  property p_contrast;
    op && wr_byte == 8'h81 ##1 wr_stb |=> contrast == $past(wr_byte) && !busy_param;
  endproperty
  a_contrast: assert property (p_contrast)
    else $error("contrast data not stored");
  property p_pump;
    op && (wr_byte & 8'hfc) == 8'h30 |=> pump_level == $past(wr_byte[1:0]);
  endproperty
  a_pump: assert property (p_pump)
    else $error("pump level wrong");
  property p_line;
    op && (wr_byte & 8'hc0) == 8'h40 |=> start_line == $past(wr_byte[5:0]);
  endproperty
  a_line: assert property (p_line)
    else $error("start line wrong");
  property p_act;
    op && (wr_byte & 8'hfe) == 8'h2e |=> scroll_active == $past(wr_byte[0]);
  endproperty
  a_act: assert property (p_act)
    else $error("scroll enable wrong");
  property p_busy;
    op && (wr_byte & 8'hfe) == 8'h26 |=> busy_param;
  endproperty
  a_busy: assert property (p_busy)
    else $error("parameter count not started");
  property p_fields;
    op && (wr_byte & 8'hfe) == 8'h26 ##1 wr_stb [*3] |=> !busy_param
      && scroll_left == $past(wr_byte[0], 4) && start_page == $past(wr_byte[2:0], 3)
      && interval_code == $past(wr_byte[2:0], 2) && end_page == $past(wr_byte[2:0]);
  endproperty
  a_fields: assert property (p_fields)
    else $error("scroll setup fields wrong");
  property p_mode;
    op && (wr_byte & 8'hfc) == 8'h28 |=> scroll_mode == ($past(wr_byte[1]) ?
      oled_cmd_pkg::mode_one_column : ($past(wr_byte[0]) ? oled_cmd_pkg::mode_single :
      oled_cmd_pkg::mode_continuous));
  endproperty
  a_mode: assert property (p_mode)
    else $error("scroll mode wrong");
  property p_unscroll;
    $fell(scroll_active) |-> ##[0:1] scroll_offset == 7'h00;
  endproperty
  a_unscroll: assert property (p_unscroll)
    else $error("offset not cleared");
  property p_rows;
    mem_line == 6'(start_line + row_index);
  endproperty
  a_rows: assert property (p_rows)
    else $error("memory line wrong");
endmodule

//--- sim/tb_oled_scroll_contrast_cmd_decoder.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Host end and decoder joined back to back
// ---------------------------------------------------------------
module tb_oled_scroll_contrast_cmd_decoder;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  logic [2:0] req_kind = 3'h0;
  logic [7:0] req_arg0 = 8'h00, req_arg1 = 8'h00, req_arg2 = 8'h00, req_arg3 = 8'h00;
  logic req_ready;
  logic frame_tick = 1'b0;
  logic [5:0] row_index = 6'h00;
  logic scroll_left, scroll_active, scroll_step, busy_param;
  logic [2:0] start_page, end_page, interval_code;
  oled_cmd_pkg::scroll_mode_t scroll_mode;
  logic [6:0] scroll_offset;
  logic [1:0] pump_level;
  logic [5:0] start_line, mem_line;
  logic [7:0] contrast;
  int errors = 0;
  int n_compared = 0;
  int steps = 0;
  oled_cmd_if bus_if ();

  always #5 clock = ~clock;
  // Step pulses last one cycle, so each is counted at its own edge.
  always @(posedge clock) if (scroll_step === 1'b1) steps++;

  oled_cmd_host u_oled_cmd_host (.clock(clock), .nrst(nrst), .req_valid(req_valid),
    .req_kind(req_kind), .req_arg0(req_arg0), .req_arg1(req_arg1), .req_arg2(req_arg2),
    .req_arg3(req_arg3), .req_ready(req_ready), .bus(bus_if));
  oled_scroll_contrast_cmd_decoder u_oled_scroll_contrast_cmd_decoder (.clock(clock),
    .nrst(nrst), .bus(bus_if), .frame_tick(frame_tick), .row_index(row_index),
    .scroll_left(scroll_left), .start_page(start_page), .end_page(end_page),
    .interval_code(interval_code), .scroll_mode(scroll_mode), .scroll_active(scroll_active),
    .scroll_offset(scroll_offset), .scroll_step(scroll_step), .pump_level(pump_level),
    .start_line(start_line), .mem_line(mem_line), .contrast(contrast),
    .busy_param(busy_param));
  oled_cmd_asserts u_oled_cmd_asserts (.clock(clock), .nrst(nrst), .wr_stb(bus_if.wr_stb),
    .wr_byte(bus_if.wr_byte), .cmd_data_select(bus_if.cmd_data_select),
    .busy_param(busy_param), .scroll_left(scroll_left), .start_page(start_page),
    .end_page(end_page), .interval_code(interval_code), .scroll_mode(scroll_mode),
    .scroll_active(scroll_active), .scroll_offset(scroll_offset), .pump_level(pump_level),
    .start_line(start_line), .row_index(row_index), .mem_line(mem_line),
    .contrast(contrast));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  // Prints the verdict and stops the run.
  task automatic end_of_test();
    if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Compares one value; case inequality so an unknown never matches.
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Waits a bounded time for the host end to be idle.
  task automatic wait_ready();
    int n;
    n = 0;
    while (req_ready !== 1'b1) begin
      @(posedge clock);
      #1;
      if (++n > 50) begin
        errors++;
        end_of_test();
      end
    end
  endtask
  // One request, held until the edge that takes it, then two edges for the settings.
  task automatic send(input logic [2:0] k, input logic [7:0] a0, a1, a2, a3);
    req_kind = k;
    req_arg0 = a0;
    req_arg1 = a1;
    req_arg2 = a2;
    req_arg3 = a3;
    req_valid = 1'b1;
    wait_ready();
    @(posedge clock);
    #1;
    req_valid = 1'b0;
    wait_ready();
    repeat (2) @(posedge clock);
    #1;
  endtask
  // A raw single byte goes out through the pass-through request kind.
  task automatic op_byte(input logic [7:0] b);
    send(3'h7, b, 8'h00, 8'h00, 8'h00);
  endtask
  // Frame pulses spaced three cycles apart.
  task automatic tick(input int n);
    repeat (n) begin
      frame_tick = 1'b1;
      @(posedge clock);
      #1;
      frame_tick = 1'b0;
      repeat (2) @(posedge clock);
      #1;
    end
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    check("start_page", 8'(start_page), 8'h00);
    check("interval", 8'(interval_code), 8'h00);
    check("end_page", 8'(end_page), 8'h07);
    check("left", 8'(scroll_left), 8'h00);
    check("mode", 8'(scroll_mode), 8'(oled_cmd_pkg::mode_continuous));
    check("active", 8'(scroll_active), 8'h00);
    check("pump", 8'(pump_level), 8'h02);
    check("line", 8'(start_line), 8'h00);
    check("contrast", contrast, 8'h80);
  endtask
  // Data bytes that look like opcodes must land in the contrast value.
  task automatic t_contrast();
    send(3'h5, 8'h3f, 8'h00, 8'h00, 8'h00);
    check("contrast", contrast, 8'h3f);
    send(3'h5, 8'h30, 8'h00, 8'h00, 8'h00);
    check("contrast", contrast, 8'h30);
    check("pump", 8'(pump_level), 8'h02);
    send(3'h5, 8'h80, 8'h00, 8'h00, 8'h00);
    check("contrast", contrast, 8'h80);
  endtask
  task automatic t_pump_line_mode();
    // Pump levels go through the host's own kind, with junk upper bits.
    for (int i = 0; i < 4; i++) begin
      send(3'h3, 8'hfc | 8'(i), 8'h00, 8'h00, 8'h00);
      check("pump", 8'(pump_level), 8'(i));
      op_byte(8'h28 | 8'(i));
      check("mode", 8'(scroll_mode), (i > 1) ? 8'h02 : 8'(i));
    end
    send(3'h1, 8'hfd, 8'h00, 8'h00, 8'h00);
    check("mode", 8'(scroll_mode), 8'h01);
    op_byte(8'h7f);
    check("line", 8'(start_line), 8'h3f);
    row_index = 6'h02;
    @(posedge clock);
    #1;
    check("mem_line", 8'(mem_line), 8'h01);
    send(3'h4, 8'hc0, 8'h00, 8'h00, 8'h00);
    check("mem_line", 8'(mem_line), 8'h02);
  endtask
  // Setup with junk upper bits, then frame-driven and column-driven steps.
  task automatic t_scroll();
    int s0;
    send(3'h0, 8'h01, 8'hfd, 8'h2f, 8'hf8);
    check("left", 8'(scroll_left), 8'h01);
    check("start_page", 8'(start_page), 8'h05);
    check("interval", 8'(interval_code), 8'h07);
    check("end_page", 8'(end_page), 8'h00);
    op_byte(8'h28);
    send(3'h2, 8'h01, 8'h00, 8'h00, 8'h00);
    check("active", 8'(scroll_active), 8'h01);
    s0 = steps;
    tick(4);
    check("steps", 8'(steps - s0), 8'h02);
    check("offset", 8'(scroll_offset), 8'h02);
    op_byte(8'h2e);
    check("active", 8'(scroll_active), 8'h00);
    check("offset", 8'(scroll_offset), 8'h00);
    op_byte(8'h2b);
    s0 = steps;
    op_byte(8'h2f);
    op_byte(8'h2f);
    tick(3);
    check("steps", 8'(steps - s0), 8'h02);
    op_byte(8'h2e);
    check("offset", 8'(scroll_offset), 8'h00);
    // Single screen makes one full pass of all columns and then stops.
    op_byte(8'h29);
    op_byte(8'h2f);
    s0 = steps;
    tick(260);
    check("steps", 8'(steps - s0), 8'h80);
    check("offset", 8'(scroll_offset), 8'h00);
    op_byte(8'h2e);
    check("active", 8'(scroll_active), 8'h00);
  endtask

  initial begin
    repeat (5) @(posedge clock);
    #1;
    nrst = 1'b1;
    t_reset();
    t_contrast();
    t_pump_line_mode();
    t_scroll();
    // A second reset in mid-run must bring every setting back.
    nrst = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    nrst = 1'b1;
    t_reset();
    end_of_test();
  end
endmodule
